// file: verilog/status_pkg.sv
// shared constants and carriers for the instrument status reporting block
package status_pkg;
  // standard event bit positions
  localparam int EV_OPC = 0;
  localparam int EV_UNUSED = 1;
  localparam int EV_QUERY = 2;
  localparam int EV_DEVICE = 3;
  localparam int EV_EXEC = 4;
  localparam int EV_CMD = 5;
  localparam int EV_USER = 6;
  localparam int EV_PON = 7;
  // questionable bit positions
  localparam int QS_POWER = 3;
  localparam int QS_CAL = 8;
  localparam int QS_TEST = 9;
  localparam logic [15:0] QS_USED = 16'h0308;
  // status byte bit positions
  localparam int SB_QUES = 3;
  localparam int SB_ESB = 5;
  localparam int SB_RQS = 6;
  // reset values
  localparam logic [7:0] EVENT_RST = 8'h80;
  localparam logic [7:0] MASK8_RST = 8'h00;
  localparam logic [15:0] MASK16_RST = 16'h0000;
  localparam logic [15:0] QUES_RST = 16'h0000;

  // host command codes
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_CLS = 3'b001,
    CMD_ESE_WR = 3'b010,
    CMD_ESR_RD = 3'b011,
    CMD_STB_RD = 3'b100,
    CMD_QEN_WR = 3'b101,
    CMD_QUES_RD = 3'b110,
    CMD_SRE_WR = 3'b111
  } cmd_t;

  typedef struct packed {
    cmd_t code;
    logic [15:0] data;
  } host_cmd_t;

  // error and event pulses from the instrument core
  typedef struct packed {
    logic opc_done;
    logic query_err;
    logic device_err;
    logic exec_err;
    logic syntax_err;
    logic user_req;
  } event_in_t;

  // measurement outcome, one per channel
  typedef struct packed {
    logic done;
    logic corrupt;
    logic overload;
    logic need_zero;
    logic window_err;
  } meas_t;

  typedef struct packed {
    logic done;
    logic zero_err;
    logic cal_err;
  } cal_t;
endpackage

// file: verilog/pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_d;

  // only s2 and s3 are compared; s1 may be metastable
  assign level_d = (s2_q == s3_q) ? s3_q : level;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level <= level_d;
    end
  end
endmodule

// file: verilog/status_reporting.sv
// status byte, standard event and questionable status logic
`timescale 1ns/1ps
module status_reporting (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // host command stream, one command per valid pulse
  input wire logic cmd_valid,
  input wire status_pkg::host_cmd_t cmd,
  output logic cmd_ready,
  output logic [15:0] resp_data,
  output logic resp_valid,
  // serial poll from bus interface
  input wire logic poll_strobe,
  output logic [7:0] poll_byte,
  // instrument events and measurement outcomes
  input wire status_pkg::event_in_t ev,
  input wire status_pkg::meas_t first_input_channel,
  input wire status_pkg::meas_t second_input_channel,
  input wire status_pkg::cal_t cal,
  // self test result pins, asynchronous
  input wire logic selftest_done_pin,
  input wire logic selftest_fail_pin,
  // other status byte sources
  input wire logic [7:0] sb_other,
  // service request line
  output logic srq
);
  logic [7:0] event_q;
  logic [7:0] event_d;
  logic [7:0] ese_q;
  logic [7:0] sre_q;
  logic [15:0] ques_q;
  logic [15:0] ques_d;
  logic [15:0] qen_q;
  logic rqs_q;
  logic busy_q;
  logic st_done;
  logic st_fail;
  logic st_done_q;

  wire logic take = cmd_valid && cmd_ready;
  wire logic is_cls = take && (cmd.code == status_pkg::CMD_CLS);
  wire logic is_esr = take && (cmd.code == status_pkg::CMD_ESR_RD);
  wire logic is_stb = take && (cmd.code == status_pkg::CMD_STB_RD);
  wire logic is_ese = take && (cmd.code == status_pkg::CMD_ESE_WR);
  wire logic is_qen = take && (cmd.code == status_pkg::CMD_QEN_WR);
  wire logic is_sre = take && (cmd.code == status_pkg::CMD_SRE_WR);
  wire logic is_ques = take && (cmd.code == status_pkg::CMD_QUES_RD);

  pin_sync done_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(selftest_done_pin),
    .level(st_done)
  );
  pin_sync fail_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin(selftest_fail_pin),
    .level(st_fail)
  );

  // summaries follow the latched registers combinationally
  wire logic esb = |(event_q & ese_q);
  wire logic qsb = |(ques_q & qen_q);
  logic [7:0] stb_base;
  always_comb begin
    stb_base = sb_other & 8'h97;
    stb_base[status_pkg::SB_QUES] = qsb;
    stb_base[status_pkg::SB_ESB] = esb;
  end
  wire logic mss = |(stb_base & sre_q & 8'hbf);

  // new event pulses, set wins over clear
  logic [7:0] ev_set;
  always_comb begin
    ev_set = 8'h00;
    ev_set[status_pkg::EV_OPC] = ev.opc_done;
    ev_set[status_pkg::EV_QUERY] = ev.query_err;
    ev_set[status_pkg::EV_DEVICE] = ev.device_err;
    ev_set[status_pkg::EV_EXEC] = ev.exec_err;
    ev_set[status_pkg::EV_CMD] = ev.syntax_err;
    ev_set[status_pkg::EV_USER] = ev.user_req;
    ev_set[status_pkg::EV_UNUSED] = 1'b0;
  end
  // clear or read empties the register, including power-on flag
  wire logic [7:0] ev_keep = (is_cls || is_esr) ? 8'h00 : event_q;
  assign event_d = (ev_keep | ev_set) & 8'hfd;

  // questionable condition bits
  wire logic pw_fault = first_input_channel.corrupt || first_input_channel.overload ||
                        first_input_channel.need_zero || first_input_channel.window_err ||
                        second_input_channel.corrupt || second_input_channel.overload ||
                        second_input_channel.need_zero || second_input_channel.window_err;
  wire logic meas_done = first_input_channel.done || second_input_channel.done;
  wire logic cal_bad = cal.zero_err || cal.cal_err;
  wire logic st_edge = st_done && !st_done_q;
  always_comb begin
    ques_d = ques_q;
    if (pw_fault) begin
      ques_d[status_pkg::QS_POWER] = 1'b1;
    end else if (meas_done) begin
      ques_d[status_pkg::QS_POWER] = 1'b0;
    end
    if (cal.done) begin
      ques_d[status_pkg::QS_CAL] = cal_bad;
    end
    if (st_edge) begin
      ques_d[status_pkg::QS_TEST] = st_fail;
    end
    ques_d = ques_d & status_pkg::QS_USED;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      event_q <= status_pkg::EVENT_RST;
      ques_q <= status_pkg::QUES_RST;
      st_done_q <= 1'b0;
    end else begin
      event_q <= event_d;
      ques_q <= ques_d;
      st_done_q <= st_done;
    end
  end

  // masks; clear-status leaves them alone
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ese_q <= status_pkg::MASK8_RST;
      sre_q <= status_pkg::MASK8_RST;
      qen_q <= status_pkg::MASK16_RST;
    end else begin
      if (is_ese) begin
        ese_q <= cmd.data[7:0];
      end
      if (is_sre) begin
        sre_q <= cmd.data[7:0];
      end
      if (is_qen) begin
        qen_q <= cmd.data & 16'h7fff;
      end
    end
  end

  // request-service bit: set on rising summary, cleared by serial poll or while the summary is low
  logic mss_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rqs_q <= 1'b0;
      mss_q <= 1'b0;
    end else begin
      mss_q <= mss;
      if (mss && !mss_q) begin
        rqs_q <= 1'b1;
      end else if (poll_strobe || !mss) begin
        rqs_q <= 1'b0;
      end
    end
  end

  // status query carries the summary in bit 6, the poll byte carries the request flag there
  logic [7:0] stb_val;
  always_comb begin
    stb_val = stb_base;
    stb_val[status_pkg::SB_RQS] = mss;
  end

  // commands run one at a time, so a status query answers only after
  // everything ahead of it has executed; costs two idle cycles per command
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      cmd_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_data <= 16'h0000;
      poll_byte <= 8'h00;
      srq <= 1'b0;
    end else begin
      cmd_ready <= !take && !busy_q;
      busy_q <= take;
      resp_valid <= is_esr || is_stb || is_ques;
      if (is_esr) begin
        resp_data <= {8'h00, event_q};
      end else if (is_stb) begin
        resp_data <= {8'h00, stb_val};
      end else if (is_ques) begin
        resp_data <= ques_q;
      end
      poll_byte <= {stb_base[7], rqs_q, stb_base[5:0]};
      srq <= rqs_q;
    end
  end

  unused_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    event_q[status_pkg::EV_UNUSED] == 1'b0)
    else $error("unused event bit set");
  ques_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (ques_q & ~status_pkg::QS_USED) == 16'h0000)
    else $error("unused questionable bit set");
  esr_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (is_esr && ev_set == 8'h00) |=> event_q == 8'h00)
    else $error("event register not cleared on read");
  esr_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ev.exec_err |=> event_q[status_pkg::EV_EXEC])
    else $error("execution error lost");
  mask_cls_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (is_cls && !is_ese) |=> $stable(ese_q))
    else $error("clear status changed mask");
  stb_resp_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_stb |=> resp_valid && resp_data[7:0] == $past(stb_val))
    else $error("status query answer wrong");
  power_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    pw_fault |=> ques_q[status_pkg::QS_POWER])
    else $error("power summary not set");
  power_clr_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (meas_done && !pw_fault) |=> !ques_q[status_pkg::QS_POWER])
    else $error("power summary not cleared");
  cal_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
    cal.done |=> ques_q[status_pkg::QS_CAL] == $past(cal_bad))
    else $error("calibration summary wrong");
  srq_line_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (mss && !mss_q) |=> ##1 srq)
    else $error("service request not raised");
  stb_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (is_stb && ev_set == 8'h00) |=> event_q == $past(event_q))
    else $error("status query changed registers");

  // every event source lands in its own bit
  opc_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ev.opc_done |=> event_q[status_pkg::EV_OPC])
    else $error("operation complete lost");

  query_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ev.query_err |=> event_q[status_pkg::EV_QUERY])
    else $error("query error lost");

  device_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ev.device_err |=> event_q[status_pkg::EV_DEVICE])
    else $error("device error lost");

  syntax_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ev.syntax_err |=> event_q[status_pkg::EV_CMD])
    else $error("syntax error lost");

  user_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ev.user_req |=> event_q[status_pkg::EV_USER])
    else $error("user request lost");

  cls_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (is_cls && ev_set == 8'h00) |=> event_q == 8'h00)
    else $error("event register not cleared by clear");

  esr_resp_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_esr |=> resp_data == {8'h00, $past(event_q)})
    else $error("event read answer wrong");

  // masks change only when written
  mask_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (is_ese && cmd.data[7:0] == 8'h00) |=> ese_q == 8'h00)
    else $error("zero write left mask set");

  mask_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !is_ese |=> $stable(ese_q))
    else $error("event mask changed unasked");

  ese_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_ese |=> ese_q == $past(cmd.data[7:0]))
    else $error("event mask write lost");

  qen_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_qen |=> qen_q == ($past(cmd.data) & 16'h7fff))
    else $error("questionable mask write wrong");

  sre_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_sre |=> sre_q == $past(cmd.data[7:0]))
    else $error("request mask write lost");

  top_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !ques_q[15] && !qen_q[15])
    else $error("questionable bit 15 set");

  // summary bits in the status query answer, request flag in the poll byte and on the service request line
  stb_esb_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_stb |=> resp_data[status_pkg::SB_ESB] == $past(|(event_q & ese_q)))
    else $error("event summary wrong");

  stb_ques_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_stb |=> resp_data[status_pkg::SB_QUES] == $past(|(ques_q & qen_q)))
    else $error("questionable summary wrong");

  stb_rqs_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_stb |=> resp_data[status_pkg::SB_RQS] == $past(mss))
    else $error("status query request bit wrong");

  poll_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (poll_strobe && !(mss && !mss_q)) |=> !rqs_q)
    else $error("poll left request flag set");

  poll_byte_a: assert property (@(posedge mclk) disable iff (sys_rst)
    poll_byte[status_pkg::SB_RQS] == $past(rqs_q))
    else $error("poll byte request bit wrong");

  srq_follow_a: assert property (@(posedge mclk) disable iff (sys_rst)
    srq == $past(rqs_q))
    else $error("service request line wrong");

  // command order: one at a time, answers only for queries
  ready_gap_a: assert property (@(posedge mclk) disable iff (sys_rst)
    take |=> !cmd_ready)
    else $error("command taken back to back");

  resp_order_a: assert property (@(posedge mclk) disable iff (sys_rst)
    resp_valid |-> $past(is_esr || is_stb || is_ques))
    else $error("answer without query");

  ques_resp_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_ques |=> resp_data == $past(ques_q))
    else $error("questionable read answer wrong");

  // questionable calibration and self test
  cal_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (cal.done && !cal_bad) |=> !ques_q[status_pkg::QS_CAL])
    else $error("calibration summary not cleared");

  test_fail_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_edge && st_fail) |=> ques_q[status_pkg::QS_TEST])
    else $error("self test failure lost");

  test_pass_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_edge && !st_fail) |=> !ques_q[status_pkg::QS_TEST])
    else $error("self test pass not cleared");

  ques_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    is_ques |=> ques_q[status_pkg::QS_TEST] == $past(ques_q[status_pkg::QS_TEST]))
    else $error("questionable read changed bits");
endmodule

// file: sim/host_model.sv
// host controller model issuing status commands
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic mclk,
  // command stream
  output status_pkg::host_cmd_t cmd,
  output logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [15:0] resp_data,
  input wire logic resp_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // request is held until the edge that sees ready, then answer is taken
  task automatic issue(input status_pkg::cmd_t code, input logic [15:0] data,
                       output logic [15:0] resp, output logic ok);
    int n;
    ok = 1'b0;
    resp = 16'h0000;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd = {code, data};
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge mclk);
      ok = (cmd_ready === 1'b1);
    end
    #1;
    cmd_valid = 1'b0;
    // released bus shows the inverse, not the stale value
    cmd = {status_pkg::CMD_NONE, ~data};
    if (code inside {status_pkg::CMD_ESR_RD, status_pkg::CMD_STB_RD,
                     status_pkg::CMD_QUES_RD}) begin
      if (resp_valid === 1'b1) resp = resp_data;
      else ok = 1'b0;
    end
  endtask
endmodule

// file: sim/tb.sv
// self-checking bench for the status reporting block
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid, cmd_ready, resp_valid, poll_strobe = 1'b0, srq;
  logic st_done = 1'b0, st_fail = 1'b0;
  logic [15:0] resp_data, r;
  logic [7:0] poll_byte, sb_other = 8'h00;
  status_pkg::host_cmd_t cmd;
  status_pkg::event_in_t ev = '0;
  status_pkg::meas_t ch_a = '0, ch_b = '0;
  status_pkg::cal_t cal = '0;
  int mismatches = 0;
  int n_tests = 0;
  always #20 mclk = ~mclk;
  status_reporting DUT (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .resp_data(resp_data), .resp_valid(resp_valid),
    .poll_strobe(poll_strobe), .poll_byte(poll_byte), .ev(ev), .first_input_channel(ch_a),
    .second_input_channel(ch_b), .cal(cal), .selftest_done_pin(st_done),
    .selftest_fail_pin(st_fail), .sb_other(sb_other), .srq(srq));
  host_model host (.mclk(mclk), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .resp_data(resp_data), .resp_valid(resp_valid));
  task automatic summarize;
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic op(input status_pkg::cmd_t code, input logic [15:0] data);
    logic ok;
    host.issue(code, data, r, ok);
    if (ok !== 1'b1) begin
      $display("MISMATCH handshake expected 1 seen 0");
      mismatches++;
      summarize();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pev(input logic [5:0] v);
    tick(1);
    ev = v;
    tick(1);
    ev = '0;
  endtask
  task automatic t_power_on;
    op(status_pkg::CMD_ESR_RD, 16'h0000);
    chk("esr_pon", 16'h0080, r);
    op(status_pkg::CMD_ESR_RD, 16'h0000);
    chk("esr_cleared", 16'h0000, r);
    op(status_pkg::CMD_QUES_RD, 16'h0000);
    chk("ques_rst", 16'h0000, r);
  endtask
  task automatic t_events;
    logic [5:0] vec [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
    int pos [6] = '{0, 2, 3, 4, 5, 6};
    for (int i = 0; i < 6; i++) begin
      pev(vec[i]);
      op(status_pkg::CMD_ESR_RD, 16'h0000);
      chk("esr_bit", 16'h0001 << pos[i], r);
    end
  endtask
  task automatic t_summary_srq;
    int n;
    sb_other = 8'h10;
    op(status_pkg::CMD_ESE_WR, 16'h0004);
    pev(6'h10);
    op(status_pkg::CMD_SRE_WR, 16'h0020);
    for (n = 0; n < 8 && srq !== 1'b1; n++) tick(1);
    chk("srq", 16'h0001, {15'h0000, srq});
    op(status_pkg::CMD_STB_RD, 16'h0000);
    chk("stb_esb", 16'h0070, r);
    poll_strobe = 1'b1;
    tick(1);
    poll_strobe = 1'b0;
    tick(2);
    chk("poll_rqs", 16'h0000, {15'h0000, poll_byte[6]});
    op(status_pkg::CMD_STB_RD, 16'h0000);
    chk("stb_after_poll", 16'h0070, r);
    op(status_pkg::CMD_CLS, 16'h0000);
    op(status_pkg::CMD_STB_RD, 16'h0000);
    chk("stb_cls", 16'h0010, r);
    pev(6'h10);
    op(status_pkg::CMD_STB_RD, 16'h0000);
    chk("mask_kept", 16'h0070, r);
    op(status_pkg::CMD_ESE_WR, 16'h0000);
    op(status_pkg::CMD_STB_RD, 16'h0000);
    chk("mask_zero", 16'h0010, r);
    sb_other = 8'h00;
    op(status_pkg::CMD_CLS, 16'h0000);
  endtask
  task automatic t_questionable;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      if (i[0]) ch_b = {1'b1, 4'h8 >> i};
      else ch_a = {1'b1, 4'h8 >> i};
      tick(1);
      ch_a = '0;
      ch_b = '0;
      op(status_pkg::CMD_QUES_RD, 16'h0000);
      chk("ques_power", 16'h0008, r);
      ch_b = 5'h10;
      tick(1);
      ch_b = '0;
      op(status_pkg::CMD_QUES_RD, 16'h0000);
      chk("ques_clean", 16'h0000, r);
    end
    cal = 3'b110;
    tick(1);
    cal = 3'b101;
    tick(1);
    cal = '0;
    op(status_pkg::CMD_QUES_RD, 16'h0000);
    chk("ques_cal", 16'h0100, r);
    cal = 3'b100;
    tick(1);
    cal = '0;
    op(status_pkg::CMD_QUES_RD, 16'h0000);
    chk("ques_cal_ok", 16'h0000, r);
    st_fail = 1'b1;
    st_done = 1'b1;
    tick(10);
    op(status_pkg::CMD_QEN_WR, 16'h0200);
    op(status_pkg::CMD_STB_RD, 16'h0000);
    chk("stb_ques", 16'h0008, r);
    op(status_pkg::CMD_QUES_RD, 16'h0000);
    chk("ques_test", 16'h0200, r);
    st_done = 1'b0;
    tick(10);
    st_fail = 1'b0;
    st_done = 1'b1;
    tick(10);
    op(status_pkg::CMD_QUES_RD, 16'h0000);
    chk("ques_test_ok", 16'h0000, r);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    tick(3);
    t_power_on();
    t_events();
    t_summary_srq();
    t_questionable();
    summarize();
  end
endmodule
